//--- core/rtcs_pkg.sv
// rtcs_pkg: shared constants, types and date helpers of the rtc event scheduler
//
// Overview of operation
// - triggers falling inside a power loss are dropped, never issued later.
// - after power up only the next real clock crossing fires; no catch-up.
// - instants skipped by a forward edit or daylight step never fire.
// - stepping back past an instant lets it fire again on recrossing.
// - unacknowledged messages survive a power cycle; only an acknowledge clears them.
// - scheduler outputs and relays come up off at power up.
// - messages one and two are never logged; pending until acknowledged.
// - date/time word packs year, month, day, hour, minutes and seconds.
// - repeat qualifier runs once to yearly; nonexistent days are skipped.
package rtcs_pkg;

  // ==========================================================================
  // widths and timing
  localparam int DW         = 32;
  localparam int AW         = 8;
  localparam int NBE        = 4;
  localparam int NSLOT      = 4;
  localparam int IW         = 4;
  localparam int DIV_W      = 28;
  localparam int CLK_HZ     = 250_000_000;
  localparam int SECOND_S   = 1;
  localparam int SEC_CYCLES = CLK_HZ * SECOND_S;

  // ==========================================================================
  // date/time word
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcs_dt_type;

  localparam logic [5:0] SEC_MAX   = 6'h3B;
  localparam logic [5:0] MIN_MAX   = 6'h3B;
  localparam logic [4:0] HOUR_MAX  = 5'h17;
  localparam logic [4:0] HOUR_MIN  = 5'h00;
  localparam logic [4:0] DAY_FIRST = 5'h01;
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_MAX   = 4'hC;
  localparam logic [3:0] MON_FEB   = 4'h2;
  localparam logic [3:0] MON_APR   = 4'h4;
  localparam logic [3:0] MON_JUN   = 4'h6;
  localparam logic [3:0] MON_SEP   = 4'h9;
  localparam logic [3:0] MON_NOV   = 4'hB;
  localparam logic [4:0] DAYS_31   = 5'h1F;
  localparam logic [4:0] DAYS_30   = 5'h1E;
  localparam logic [4:0] DAYS_29   = 5'h1D;
  localparam logic [4:0] DAYS_28   = 5'h1C;

  // ==========================================================================
  // modes and states
  typedef enum logic [2:0] {
    Q_ONCE = 3'b000, Q_SECOND = 3'b001, Q_MINUTE = 3'b010, Q_HOURLY = 3'b011,
    Q_DAILY = 3'b100, Q_MONTHLY = 3'b101, Q_YEARLY = 3'b110
  } rtcs_qual_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00, RD_LOAD = 2'b01, RD_DONE = 2'b10
  } rtcs_rd_type;

  typedef struct packed {
    logic [3:0] on;
    logic [3:0] off;
  } rtcs_act_type;

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_NOW     = 8'h00;
  localparam logic [7:0] REG_DST     = 8'h04;
  localparam logic [7:0] REG_MSG     = 8'h08;
  localparam logic [7:0] REG_ISTAT   = 8'h0C;
  localparam logic [7:0] REG_IMASK   = 8'h10;
  localparam logic [7:0] REG_OUTS    = 8'h14;
  localparam logic [1:0] SLOT_REGION = 2'h1;
  localparam logic [1:0] FLD_SEL     = 2'h0;
  localparam logic [1:0] FLD_QUAL    = 2'h1;
  localparam logic [1:0] FLD_START   = 2'h2;
  localparam int DST_FWD  = 0;
  localparam int DST_BACK = 1;
  localparam int SLOT_MSG1 = 2;
  localparam int OUT_DO1  = 0;
  localparam int OUT_RLY1 = 2;
  localparam logic [7:0] ACT_NONE       = 8'h00;
  localparam logic [7:0] ACT_PLAIN_LAST = 8'h08;
  localparam logic [7:0] ACT_DO1_FIRST  = 8'h0C;
  localparam logic [7:0] ACT_RLY1_FIRST = 8'h12;
  localparam logic [7:0] ACT_LAST       = 8'h17;

  // ==========================================================================
  // helpers
  function automatic logic [4:0] days_in_month(input logic [3:0] m, input logic [5:0] y);
    if (m == MON_FEB) begin
      return (y[1:0] == 2'h0) ? DAYS_29 : DAYS_28;
    end
    if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV) begin
      return DAYS_30;
    end
    return DAYS_31;
  endfunction

  // one second forward, carrying through month lengths
  function automatic rtcs_dt_type dt_inc(input rtcs_dt_type t);
    rtcs_dt_type n;
    n = t;
    n.second = (t.second == SEC_MAX) ? 6'h00 : t.second + 6'h01;
    if (t.second == SEC_MAX) begin
      n.minute = (t.minute == MIN_MAX) ? 6'h00 : t.minute + 6'h01;
      if (t.minute == MIN_MAX) begin
        n.hour = (t.hour == HOUR_MAX) ? HOUR_MIN : t.hour + 5'h01;
        if (t.hour == HOUR_MAX) begin
          n.day = (t.day >= days_in_month(t.month, t.year)) ? DAY_FIRST : t.day + 5'h01;
          if (t.day >= days_in_month(t.month, t.year)) begin
            n.month = (t.month == MON_MAX) ? MON_FIRST : t.month + 4'h1;
            n.year  = (t.month == MON_MAX) ? t.year + 6'h01 : t.year;
          end
        end
      end
    end
    return n;
  endfunction

  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] o, input logic [DW-1:0] w,
                                             input logic [NBE-1:0] be);
    logic [DW-1:0] r;
    r = o;
    for (int b = 0; b < NBE; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [IW-1:0] slot_idx(input int s, input logic [1:0] f);
    return {2'(s), f};
  endfunction

  function automatic rtcs_act_type act_decode(input logic [7:0] code);
    rtcs_act_type a;
    logic [7:0]   k;
    a = '0;
    k = code - 8'h01;
    if (code != ACT_NONE && code <= ACT_PLAIN_LAST) begin
      a.on[k[2:1]]  = ~k[0];
      a.off[k[2:1]] = k[0];
    end else if (code >= ACT_DO1_FIRST && code < ACT_RLY1_FIRST) begin
      a.on[OUT_DO1]  = ~code[0];
      a.off[OUT_DO1] = code[0];
    end else if (code >= ACT_RLY1_FIRST && code <= ACT_LAST) begin
      a.on[OUT_RLY1]  = ~code[0];
      a.off[OUT_RLY1] = code[0];
    end
    return a;
  endfunction

endpackage

//--- core/rtcs_slot_mem.sv
// rtcs_slot_mem: register file holding the scheduler slot words
`timescale 1ns/10ps
module rtcs_slot_mem #(
  parameter int DEPTH = 16
) (
  // clock
  input  wire logic                                   clk,
  // write port
  input  wire logic                                   wr_en,
  input  wire logic [rtcs_pkg::IW-1:0]                wr_idx,
  input  wire logic [rtcs_pkg::DW-1:0]                wr_data,
  input  wire logic [rtcs_pkg::NBE-1:0]               wr_be,
  // read port
  input  wire logic [rtcs_pkg::IW-1:0]                rd_idx,
  output logic      [rtcs_pkg::DW-1:0]                rd_data,
  // all words for the comparators
  output logic      [DEPTH-1:0][rtcs_pkg::DW-1:0]     words
);
  import rtcs_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rd;
  } rtcs_mem_type;

  rtcs_mem_type st;
  rtcs_mem_type next_st;

  // no reset: contents model the retained parameter store
  always_comb begin
    next_st = st;
    next_st.rd = st.mem[rd_idx];
    if (wr_en) begin
      next_st.mem[wr_idx] = be_merge(st.mem[wr_idx], wr_data, wr_be);
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign rd_data = st.rd;
  assign words   = st.mem;

endmodule

//--- core/rtcs_match.sv
// rtcs_match: crossing test of one slot against the next clock value
`timescale 1ns/10ps
module rtcs_match (
  // slot and time
  input  wire logic [rtcs_pkg::DW-1:0] now_word,
  input  wire logic [rtcs_pkg::DW-1:0] start_word,
  input  wire logic [2:0]              qual,
  // result
  output logic                         hit
);
  import rtcs_pkg::*;

  rtcs_dt_type n;
  rtcs_dt_type s;

  assign n = rtcs_dt_type'(now_word);
  assign s = rtcs_dt_type'(start_word);

  // fields above the repeat unit are free; a missing day never matches
  always_comb begin
    hit = 1'b0;
    if (now_word >= start_word) begin
      case (rtcs_qual_type'(qual))
        Q_ONCE:    hit = (now_word == start_word);
        Q_SECOND:  hit = 1'b1;
        Q_MINUTE:  hit = (n.second == s.second);
        Q_HOURLY:  hit = ({n.minute, n.second} == {s.minute, s.second});
        Q_DAILY:   hit = ({n.hour, n.minute, n.second} == {s.hour, s.minute, s.second});
        Q_MONTHLY: hit = ({n.day, n.hour, n.minute, n.second}
                          == {s.day, s.hour, s.minute, s.second});
        Q_YEARLY:  hit = ({n.month, n.day, n.hour, n.minute, n.second}
                          == {s.month, s.day, s.hour, s.minute, s.second});
        default:   hit = 1'b0;
      endcase
    end
  end

endmodule

//--- core/rtcs_top.sv
// rtcs_top: rtc event scheduler with avalon register access
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module rtcs_top #(
  parameter int SECOND_CYCLES = rtcs_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // avalon-mm slave
  input  wire logic [rtcs_pkg::AW-1:0]    avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [rtcs_pkg::DW-1:0]    avs_writedata,
  input  wire logic [rtcs_pkg::NBE-1:0]   avs_byteenable,
  output logic      [rtcs_pkg::DW-1:0]    avs_readdata,
  output logic                            avs_waitrequest,
  // retained state from the backup domain
  input  wire logic [rtcs_pkg::DW-1:0]    backup_datetime,
  input  wire logic [1:0]                 backup_msg_pending,
  // drive outputs
  output logic                            digital_out_1,
  output logic                            digital_out_2,
  output logic                            relay_out_1,
  output logic                            relay_out_2,
  // operator messages and log
  output logic [1:0]                      msg_active,
  output logic [1:0]                      action_log_pulse,
  output logic [rtcs_pkg::DW-1:0]         current_datetime_word,
  // interrupt
  output logic                            irq
);
  import rtcs_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic              restored;
    logic [DIV_W-1:0]  div;
    rtcs_dt_type       now;
    logic [NSLOT-1:0]  slot_ok;
    logic [1:0]        msg_pend;
    logic [3:0]        outs;
    logic [1:0]        act_log;
    logic [NSLOT-1:0]  istat;
    logic [NSLOT-1:0]  imask;
    rtcs_rd_type       rd_phase;
    logic [DW-1:0]     rdata;
  } rtcs_state_type;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SECOND_CYCLES - 1);

  rtcs_state_type st;
  rtcs_state_type next_st;

  // ==========================================================================
  // slot storage and comparators
  logic [DW-1:0]              mem_rd;
  logic [2**IW-1:0][DW-1:0]   words;
  logic                       slot_wr;
  logic [NSLOT-1:0]           hit;
  logic [NSLOT-1:0]           sel_nz;
  logic [NSLOT-1:0]           fire;
  rtcs_dt_type                nxt_now;
  logic                       tick;
  logic                       time_edit;
  logic                       rd_accept;
  logic                       in_slots;
  logic [1:0]                 slot_fld;

  assign in_slots = (avs_address[7:6] == SLOT_REGION);
  assign slot_fld = avs_address[3:2];
  assign slot_wr  = avs_write && in_slots && (slot_fld != 2'h3);

  rtcs_slot_mem #(
    .DEPTH (2**IW)
  ) u_mem (
    .clk     (clk),
    .wr_en   (slot_wr),
    .wr_idx  (avs_address[5:2]),
    .wr_data (avs_writedata),
    .wr_be   (avs_byteenable),
    .rd_idx  (avs_address[5:2]),
    .rd_data (mem_rd),
    .words   (words)
  );

  assign nxt_now = dt_inc(st.now);

  // every slot is tested against the value the clock is about to reach
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot
    rtcs_match u_match (
      .now_word   (DW'(nxt_now)),
      .start_word (words[slot_idx(i, FLD_START)]),
      .qual       (words[slot_idx(i, FLD_QUAL)][2:0]),
      .hit        (hit[i])
    );
    assign sel_nz[i] = (words[slot_idx(i, FLD_SEL)][7:0] != ACT_NONE);
  end

  // ==========================================================================
  // second divider and crossing detection
  // no tick before restore, so nothing missed while off is replayed
  assign tick = st.restored && (st.div == DIV_LAST);

  // edits and daylight steps load time without a crossing
  assign time_edit = avs_write && (avs_address == REG_NOW || avs_address == REG_DST);

  // only a one-second advance is a crossing; after a step back it recurs
  assign fire = (tick && !time_edit) ? (hit & sel_nz & st.slot_ok) : '0;

  // ==========================================================================
  // bus handshake
  // reads wait two cycles: address to memory, then into the answer register
  assign avs_waitrequest = avs_read && (st.rd_phase != RD_DONE);
  assign rd_accept       = avs_read && (st.rd_phase == RD_DONE);

  // ==========================================================================
  // next state
  always_comb begin
    rtcs_act_type act;
    act = '0;
    next_st = st;
    next_st.act_log = '0;

    // catch the retained time and messages once, just after release
    if (!st.restored) begin
      next_st.restored = 1'b1;
      next_st.now      = rtcs_dt_type'(backup_datetime);
      next_st.msg_pend = backup_msg_pending;
      next_st.div      = '0;
    end else begin
      next_st.div = (st.div == DIV_LAST) ? '0 : st.div + 1'b1;
      if (tick) begin
        next_st.now = nxt_now;
      end
    end

    // read sequencing
    case (st.rd_phase)
      RD_IDLE: begin
        if (avs_read) begin
          next_st.rd_phase = RD_LOAD;
        end
      end
      RD_LOAD: begin
        next_st.rd_phase = RD_DONE;
        next_st.rdata    = '0;
        if (in_slots) begin
          next_st.rdata = (slot_fld == 2'h3) ? '0 : mem_rd;
        end else begin
          case (avs_address)
            REG_NOW:   next_st.rdata = DW'(st.now);
            REG_MSG:   next_st.rdata = DW'(st.msg_pend);
            REG_ISTAT: next_st.rdata = DW'(st.istat);
            REG_IMASK: next_st.rdata = DW'(st.imask);
            REG_OUTS:  next_st.rdata = DW'(st.outs);
            default:   next_st.rdata = '0;
          endcase
        end
      end
      RD_DONE: begin
        next_st.rd_phase = RD_IDLE;
      end
      default: begin
        next_st.rd_phase = RD_IDLE;
      end
    endcase

    // status cleared by the accepted read, before new events are merged
    if (rd_accept && avs_address == REG_ISTAT) begin
      next_st.istat = '0;
    end

    // register writes
    if (avs_write && st.restored) begin
      if (avs_address == REG_NOW) begin
        next_st.now = rtcs_dt_type'(be_merge(DW'(st.now), avs_writedata, avs_byteenable));
      end
      if (avs_address == REG_DST) begin
        // the step replaces this cycle's one-second advance; forward wins
        next_st.now = st.now;
        if (avs_writedata[DST_FWD]) begin
          if (st.now.hour != HOUR_MAX) begin
            next_st.now.hour = st.now.hour + 5'h01;
          end
        end else if (avs_writedata[DST_BACK] && st.now.hour != HOUR_MIN) begin
          next_st.now.hour = st.now.hour - 5'h01;
        end
      end
      if (avs_address == REG_MSG) begin
        next_st.msg_pend = st.msg_pend & ~avs_writedata[1:0];
      end
      if (avs_address == REG_IMASK) begin
        next_st.imask = avs_writedata[NSLOT-1:0];
      end
      if (slot_wr && slot_fld == FLD_SEL) begin
        next_st.slot_ok[avs_address[5:4]] = 1'b1;
      end
    end

    // actions switch outputs; later slot wins a conflict
    for (int a = 0; a < SLOT_MSG1; a++) begin
      act = act_decode(words[slot_idx(a, FLD_SEL)][7:0]);
      if (fire[a]) begin
        next_st.outs = (next_st.outs & ~act.off) | act.on;
      end
    end
    next_st.act_log = fire[SLOT_MSG1-1:0];

    // messages latch until acknowledged and bypass the log; set beats ack
    next_st.msg_pend = next_st.msg_pend | fire[NSLOT-1:SLOT_MSG1];

    // event status, set wins over read clear
    next_st.istat = next_st.istat | fire;
  end

  // outputs come up off regardless of the state before power loss
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{restored: 1'b0, div: '0, now: '0, slot_ok: '0, msg_pend: '0,
             outs: '0, act_log: '0, istat: '0, imask: '0, rd_phase: RD_IDLE,
             rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata          = st.rdata;
  assign digital_out_1         = st.outs[0];
  assign digital_out_2         = st.outs[1];
  assign relay_out_1           = st.outs[2];
  assign relay_out_2           = st.outs[3];
  assign msg_active            = st.msg_pend;
  assign action_log_pulse      = st.act_log;
  assign current_datetime_word = DW'(st.now);
  assign irq                   = |(st.istat & st.imask);

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_no_early_fire: assert property (
    !st.restored |-> fire == '0
  ) else $error("slot fired before time was restored");

  chk_fire_on_tick: assert property (
    (|fire) |-> tick && st.div == DIV_LAST
  ) else $error("slot fired off the second boundary");

  chk_edit_no_fire: assert property (
    avs_write && avs_address == REG_NOW |-> fire == '0
  ) else $error("time edit produced a trigger");

  chk_dst_forward: assert property (
    avs_write && avs_address == REG_DST && avs_writedata[DST_FWD]
      && st.now.hour != HOUR_MAX && st.restored
      |=> st.now.hour == $past(st.now.hour) + 5'h01
  ) else $error("daylight step forward did not add one hour");

  chk_step_back: assert property (
    avs_write && avs_address == REG_DST && !avs_writedata[DST_FWD]
      && avs_writedata[DST_BACK] && st.now.hour != HOUR_MIN && st.restored
      |=> st.now.hour == $past(st.now.hour) - 5'h01
  ) else $error("daylight step back did not remove one hour");

  chk_msg_persist: assert property (
    st.msg_pend[0] && !(avs_write && avs_address == REG_MSG && avs_writedata[0])
      |=> st.msg_pend[0]
  ) else $error("message one cleared without acknowledge");

  chk_msg_restore: assert property (
    $rose(st.restored) |-> st.msg_pend == $past(backup_msg_pending)
  ) else $error("pending messages not restored after power up");

  chk_outs_off: assert property (
    !st.restored |-> st.outs == 4'h0 ##1 st.outs == 4'h0
  ) else $error("outputs not off after power up");

  chk_msg_not_logged: assert property (
    fire[SLOT_MSG1] && fire[1:0] == 2'b00 |=> action_log_pulse == 2'b00 && msg_active[0]
  ) else $error("message logged or not latched");

  chk_second_step: assert property (
    tick && !time_edit |=> st.now == dt_inc($past(st.now))
  ) else $error("clock did not advance one second");

  chk_once_exact: assert property (
    fire[0] && words[slot_idx(0, FLD_QUAL)][2:0] == Q_ONCE
      |-> DW'(nxt_now) == words[slot_idx(0, FLD_START)]
  ) else $error("once slot fired off its start instant");

  chk_read_wait: assert property (
    avs_read && st.rd_phase == RD_IDLE |-> avs_waitrequest ##2 !avs_waitrequest
  ) else $error("read answer not two cycles late");

endmodule

//--- test/rtcs_backup_model.sv
// battery-backed store seen by the scheduler across power cycles
`timescale 1ns/10ps
module rtcs_backup_model #(
  parameter logic [31:0] START  = 32'h4042_0000,
  parameter int          LOSS_S = 14
) (
  // clock and main power
  input  wire logic        clk,
  input  wire logic        reset_n,
  // live state of the scheduler
  input  wire logic [31:0] current_datetime_word,
  input  wire logic [1:0]  msg_active,
  // retained state
  output logic      [31:0] backup_datetime,
  output logic      [1:0]  backup_msg_pending
);
  logic up = 1'b0;

  // ==========================================================================
  // retention
  initial begin
    backup_datetime = START;
    backup_msg_pending = 2'h0;
  end

  // restore edge skipped: live outputs are still zero then
  // synchronous, so the last capture before power loss cannot race the offset
  always @(posedge clk) begin
    if (!reset_n) begin
      if (up) begin
        // battery clock keeps running while main power is off
        backup_datetime[5:0] <= backup_datetime[5:0] + 6'(LOSS_S);
      end
      up <= 1'b0;
    end else begin
      if (up) begin
        backup_datetime <= current_datetime_word;
        backup_msg_pending <= msg_active;
      end
      up <= 1'b1;
    end
  end
endmodule

//--- test/testbench.sv
// self-checking bench for the rtc event scheduler
`timescale 1ns/10ps
module testbench;
  import rtcs_pkg::*;
  // ==========================================================================
  // signals
  localparam logic [31:0] T0 = 32'h4042_0000;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] bk_time;
  logic [1:0]  bk_msg;
  logic        do1;
  logic        do2;
  logic        ro1;
  logic        ro2;
  logic [1:0]  msg_active;
  logic [1:0]  pulse;
  logic [31:0] now_word;
  logic        irq;
  logic [31:0] q;
  int          err_total = 0;
  int          checked = 0;
  int          pulse_a1 = 0;
  int          pulse_a2 = 0;
  int          sel[3] = '{1, 2, 1};
  int          st[3] = '{10, 20, 30};

  always #2 clk = ~clk;

  // one second is 8 clocks here
  rtcs_top #(.SECOND_CYCLES(8)) uut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .backup_datetime(bk_time), .backup_msg_pending(bk_msg), .digital_out_1(do1),
    .digital_out_2(do2), .relay_out_1(ro1), .relay_out_2(ro2), .msg_active(msg_active),
    .action_log_pulse(pulse), .current_datetime_word(now_word), .irq(irq));

  rtcs_backup_model #(.START(T0)) backup (.clk(clk), .reset_n(reset_n),
    .current_datetime_word(now_word), .msg_active(msg_active),
    .backup_datetime(bk_time), .backup_msg_pending(bk_msg));

  always @(negedge clk) begin
    pulse_a1 += int'(pulse[0] === 1'b1);
    pulse_a2 += int'(pulse[1] === 1'b1);
  end

  // ==========================================================================
  // tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // bounded wait for output 1 or message 1 to reach a level
  task automatic till(input logic m, input logic v);
    int n;
    n = 0;
    while ((m ? msg_active[0] : do1) !== v && n < 800) begin
      @(negedge clk);
      n++;
    end
    chk("wait level", 32'(v), 32'(m ? msg_active[0] : do1));
  endtask

  task automatic finish_test;
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_total++;
    finish_test();
  end

  // ==========================================================================
  // tests
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("outputs", 32'h0, {do1, do2, ro1, ro2});
    bus(1, REG_IMASK, 32'hF, q);
    for (int s = 0; s < 3; s++) begin
      bus(1, 8'h40 + 8'(s * 16), 32'(sel[s]), q);
      bus(1, 8'h44 + 8'(s * 16), {29'h0, Q_ONCE}, q);
      bus(1, 8'h48 + 8'(s * 16), T0 + 32'(st[s]), q);
    end
    bus(1, REG_NOW, T0 + 32'd5, q);
    till(0, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    bus(0, REG_ISTAT, 32'h0, q);
    chk("status", 32'h1, q);
    chk("irq", 32'h0, 32'(irq));
    till(0, 1'b0);
    // step back across :10 so it fires a second time
    bus(1, REG_NOW, T0 + 32'd8, q);
    till(0, 1'b1);
    // jump over :20 so output 1 is never switched off
    bus(1, REG_NOW, T0 + 32'd25, q);
    till(1, 1'b1);
    chk("output 1", 32'h1, 32'(do1));
    chk("action 1 pulses", 32'd2, 32'(pulse_a1));
    chk("action 2 pulses", 32'd1, 32'(pulse_a2));
    // power loss of 14 s passes over the :40 instant
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("outputs", 32'h0, {do1, do2, ro1, ro2});
    chk("message", 32'h1, 32'(msg_active));
    bus(1, 8'h40, 32'h1, q);
    bus(1, 8'h44, {29'h0, Q_MINUTE}, q);
    bus(1, 8'h48, T0 + 32'd40, q);
    repeat (40) @(negedge clk);
    chk("output 1", 32'h0, 32'(do1));
    till(0, 1'b1);
    chk("time", T0 + 32'h40 + 32'd40, now_word);
    chk("irq masked", 32'h0, 32'(irq));
    bus(0, REG_ISTAT, 32'h0, q);
    chk("status", 32'h1, q);
    chk("message", 32'h1, 32'(msg_active));
    bus(1, REG_MSG, 32'h1, q);
    chk("message", 32'h0, 32'(msg_active));
    bus(0, REG_OUTS, 32'h0, q);
    chk("output register", 32'h1, q);
    // daylight steps move only the hour
    bus(1, REG_NOW, T0, q);
    bus(1, REG_DST, 32'h1, q);
    bus(0, REG_NOW, 32'h0, q);
    chk("hour forward", 32'h1, 32'(q[16:12]));
    bus(1, REG_DST, 32'h2, q);
    bus(0, REG_NOW, 32'h0, q);
    chk("hour back", 32'h0, 32'(q[16:12]));
    bus(0, 8'hFC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    finish_test();
  end
endmodule
